// >>> logic/disk_bus_port.v
/*
 Disk-side bus port: decodes the target id straps, follows the host's
 direction and phase lines, answers each request with one acknowledge,
 and moves one byte with odd parity per handshake.
 Assumes all bus lines are active low and asynchronous to clk_sys.
*/
// Contract
// - Id from low straps weighted 1,2,4
// - Drive holds one id 0..7
// - Direction low: drive outputs; high: drive accepts
// - Phase low means data, high control
// - Acknowledge only answers an asserted request
`timescale 1ns/10ps
`include "disk_port_consts.vh"

module disk_bus_port #(
   parameter DATA_W = `DATA_W
) (
   // Clock and reset
   input wire clk_sys,
   input wire reset,
   // Target id straps
   input wire id_weight_one_strap_n,
   input wire id_weight_two_strap_n,
   input wire id_weight_four_strap_n,
   // Phase lines
   input wire io_dir_n,
   input wire cd_phase_n,
   // Handshake
   input wire req_n,
   output reg ack_n_ff,
   // Data bus, three-signal form
   input wire [DATA_W-1:0] db_n_in,
   input wire parity_n_in,
   output reg [DATA_W-1:0] db_n_out_ff,
   output reg parity_n_out_ff,
   output reg db_oe_ff,
   // User side
   input wire [DATA_W-1:0] tx_byte,
   output reg [`ID_W-1:0] target_id_ff,
   output reg [DATA_W-1:0] rx_byte_ff,
   output reg rx_is_data_ff,
   output reg rx_valid_ff,
   output reg rx_parity_err_ff,
   output reg tx_taken_ff,
   output reg phase_data_ff
);

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   localparam N_SYNC = DATA_W + 7;

   wire [N_SYNC-1:0] raw_pins;
   wire [N_SYNC-1:0] sync_pins;

   assign raw_pins = {id_weight_four_strap_n, id_weight_two_strap_n, id_weight_one_strap_n,
                      io_dir_n, cd_phase_n, req_n, parity_n_in, db_n_in};

   genvar gi;
   generate
      for (gi = 0; gi < N_SYNC; gi = gi + 1) begin : g_sync
         pin_sync #(.RESET_VAL(`PIN_IDLE_N)) u_sync (
            .clk_sys(clk_sys),
            .reset(reset),
            .pin_in(raw_pins[gi]),
            .level_ff(sync_pins[gi])
         );
      end
   endgenerate

   wire [DATA_W-1:0] s_db_n;
   wire s_par_n;
   wire s_req_n;
   wire s_cd_n;
   wire s_io_n;
   wire [`ID_W-1:0] s_strap_n;

   assign s_db_n = sync_pins[DATA_W-1:0];
   assign s_par_n = sync_pins[DATA_W];
   assign s_req_n = sync_pins[DATA_W+1];
   assign s_cd_n = sync_pins[DATA_W+2];
   assign s_io_n = sync_pins[DATA_W+3];
   assign s_strap_n = sync_pins[DATA_W+6:DATA_W+4];

   // ----------------------------------------
   // Id decode and phase
   // ----------------------------------------
   // strap weight decode
   wire [`ID_W-1:0] nxt_target_id;
   assign nxt_target_id = ~s_strap_n;

   wire to_host;
   assign to_host = (s_io_n == `DIR_TO_HOST_LVL);

   wire is_data;
   assign is_data = (s_cd_n == `PHASE_DATA_LVL);

   wire [DATA_W-1:0] rx_true;
   wire rx_par_ok;
   wire tx_par;
   assign rx_true = ~s_db_n;
   assign rx_par_ok = ^{rx_true, ~s_par_n};
   assign tx_par = ~(^tx_byte);

   // ----------------------------------------
   // Handshake state machine
   // ----------------------------------------
   reg [1:0] state_ff;
   reg [1:0] nxt_state;

   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         `ST_IDLE: begin
            if (!s_req_n) begin
               nxt_state = `ST_ACK;
            end
         end
         `ST_ACK: begin
            if (s_req_n) begin
               nxt_state = `ST_IDLE;
            end
         end
         default: begin
            nxt_state = `ST_IDLE;
         end
      endcase
   end

   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_ff <= `ST_IDLE;
         ack_n_ff <= `PIN_IDLE_N;
         db_n_out_ff <= {DATA_W{`PIN_IDLE_N}};
         parity_n_out_ff <= `PIN_IDLE_N;
         db_oe_ff <= 1'b0;
         target_id_ff <= `ID_RESET;
         rx_byte_ff <= `BYTE_RESET;
         rx_is_data_ff <= 1'b0;
         rx_valid_ff <= 1'b0;
         rx_parity_err_ff <= 1'b0;
         tx_taken_ff <= 1'b0;
         phase_data_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         target_id_ff <= nxt_target_id;
         phase_data_ff <= is_data;
         db_oe_ff <= to_host;
         rx_valid_ff <= 1'b0;
         tx_taken_ff <= 1'b0;
         if (state_ff == `ST_IDLE && !s_req_n) begin
            if (to_host) begin
               db_n_out_ff <= ~tx_byte;
               parity_n_out_ff <= ~tx_par;
               tx_taken_ff <= 1'b1;
            end else begin
               rx_byte_ff <= rx_true;
               rx_is_data_ff <= is_data;
               rx_parity_err_ff <= ~rx_par_ok;
               rx_valid_ff <= 1'b1;
            end
         end
         ack_n_ff <= (nxt_state == `ST_ACK) ? 1'b0 : `PIN_IDLE_N;
      end
   end

endmodule

// >>> inc/disk_port_consts.vh
/*
 Constants for the disk-side bus port: strap weights, phase levels,
 data width and synchroniser depth.
 Assumes inclusion by bare name from the logic files.
*/
`ifndef DISK_PORT_CONSTS_VH
`define DISK_PORT_CONSTS_VH

// ----------------------------------------
// Widths
// ----------------------------------------
`define DATA_W 8
`define ID_W 3
`define SYNC_W 3

// ----------------------------------------
// Target id strap weights (bit index)
// ----------------------------------------
`define ID_BIT_ONE 0
`define ID_BIT_TWO 1
`define ID_BIT_FOUR 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ID_RESET 3'h0
`define BYTE_RESET 8'h00
`define PIN_IDLE_N 1'h1

// ----------------------------------------
// Phase line levels (bus side, active low)
// ----------------------------------------
`define DIR_TO_HOST_LVL 1'h0
`define PHASE_DATA_LVL 1'h0

// ----------------------------------------
// Handshake states
// ----------------------------------------
`define ST_IDLE 2'h0
`define ST_ACK 2'h1
`define ST_WAIT_REL 2'h2

`endif

// >>> logic/pin_sync.v
/*
 Three-stage synchroniser for one pin; a change is accepted once the
 second and third stages agree.
 Assumes an asynchronous input and clk_sys at 100 MHz.
*/
`timescale 1ns/10ps
`include "disk_port_consts.vh"

module pin_sync #(
   parameter [0:0] RESET_VAL = 1'b1
) (
   // Clock and reset
   input wire clk_sys,
   input wire reset,
   // Pin and filtered level
   input wire pin_in,
   output reg level_ff
);

   reg [`SYNC_W-1:0] stage_ff;

   // ----------------------------------------
   // Sync chain and agreement filter
   // ----------------------------------------
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         stage_ff <= {`SYNC_W{RESET_VAL}};
         level_ff <= RESET_VAL;
      end else begin
         stage_ff <= {stage_ff[`SYNC_W-2:0], pin_in};
         if (stage_ff[1] == stage_ff[2]) begin
            level_ff <= stage_ff[2];
         end
      end
   end

endmodule

// >>> tb/disk_bus_port_chk.sv
/*
 Checker for the disk bus port, bound to its top module.
 Assumes bench inputs change only on clk_sys edges.
*/
`timescale 1ns/10ps
module disk_chk(
   // Clock, reset
   input wire clk_sys, reset,
   // Bus and user side
   input wire id_weight_one_strap_n, id_weight_two_strap_n, id_weight_four_strap_n,
   input wire io_dir_n, cd_phase_n, req_n, ack_n_ff, db_oe_ff, parity_n_out_ff,
   input wire tx_taken_ff, phase_data_ff, rx_valid_ff,
   input wire [7:0] db_n_out_ff, tx_byte,
   input wire [2:0] target_id_ff
);
   wire [2:0] strap_w = {id_weight_four_strap_n, id_weight_two_strap_n, id_weight_one_strap_n};
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   id_decode_a: assert property ($stable(strap_w)[*6] |-> target_id_ff == ~strap_w)
      else $error("id mismatch");
   dir_oe_a: assert property ($stable(io_dir_n)[*6] |-> db_oe_ff == !io_dir_n)
      else $error("drive enable mismatch");
   phase_a: assert property ($stable(cd_phase_n)[*6] |-> phase_data_ff == !cd_phase_n)
      else $error("phase mismatch");
   ack_cause_a: assert property ($fell(ack_n_ff) |-> !$past(req_n, 2))
      else $error("ack without request");
   ack_rel_a: assert property (req_n[*6] |-> ack_n_ff)
      else $error("ack held after release");
   odd_par_a: assert property (tx_taken_ff |-> !(^{db_n_out_ff, parity_n_out_ff}))
      else $error("parity not odd");
   tx_byte_a: assert property (tx_taken_ff |-> db_n_out_ff == ~tx_byte && !ack_n_ff)
      else $error("sent byte wrong");
   rx_valid_a: assert property (rx_valid_ff |-> !ack_n_ff && !db_oe_ff)
      else $error("receive pulse outside handshake");
endmodule
bind disk_bus_port disk_chk disk_chk_i(.*);

// >>> tb/host_model.sv
/*
 Host side model: runs one request/acknowledge transfer per call.
 Assumes pull-ups on all bus lines when the host releases them.
*/
`timescale 1ns/10ps
module host_model(
   // Clock and answer
   input wire clk_sys,
   input wire ack_n_ff,
   // Lines driven by host
   output reg req_n = 1'h1,
   output reg io_dir_n = 1'h1,
   output reg cd_phase_n = 1'h1,
   output reg [7:0] db_n_in = 8'hFF,
   output reg parity_n_in = 1'h1
);
   task xfer(input d, c, bad, input [7:0] b);
      integer k;
      begin
         @(posedge clk_sys);
         io_dir_n <= d;
         cd_phase_n <= c;
         db_n_in <= d ? ~b : 8'hFF;
         parity_n_in <= d ? (^b ^ bad) : 1'h1;
         req_n <= 1'h0;
         for (k = 0; k < 20 && ack_n_ff; k++) @(posedge clk_sys);
         req_n <= 1'h1;
         for (k = 0; k < 20 && !ack_n_ff; k++) @(posedge clk_sys);
         db_n_in <= 8'hFF;
         parity_n_in <= 1'h1;
      end
   endtask
endmodule

// >>> tb/disk_bus_port_bench.sv
/*
 Bench for the disk bus port: straps, receive and send transfers.
 Assumes host_model and the bound checker.
*/
`timescale 1ns/10ps
module disk_bus_port_bench;
   reg clk_sys = 1'h0, reset = 1'h1;
   reg id_weight_one_strap_n = 1'h1, id_weight_two_strap_n = 1'h1, id_weight_four_strap_n = 1'h1;
   reg [7:0] tx_byte = 8'h96;
   wire io_dir_n, cd_phase_n, req_n, parity_n_in, ack_n_ff, parity_n_out_ff, db_oe_ff;
   wire rx_is_data_ff, rx_valid_ff, rx_parity_err_ff, tx_taken_ff, phase_data_ff;
   wire [7:0] db_n_in, db_n_out_ff, rx_byte_ff;
   wire [2:0] target_id_ff;
   integer err_count = 0, n_tests = 0, i;
   integer n_rx_pulse = 0, n_tx_pulse = 0;
   disk_bus_port disk_bus_port_i(.*);
   host_model host_model_i(.*);
   initial forever #5 clk_sys = ~clk_sys;
   // Pulse counters for the one-cycle strobes
   always @(posedge clk_sys) begin
      if (rx_valid_ff) n_rx_pulse <= n_rx_pulse + 1;
      if (tx_taken_ff) n_tx_pulse <= n_tx_pulse + 1;
   end
   task chk(input [7:0] seen, exp, input [63:0] nm);
      begin
         n_tests++;
         if (seen !== exp) begin
            err_count++;
            $display("wrong value %0s exp %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task wrap_up;
      begin
         if (err_count == 0 && n_tests > 0) $display("verification passed");
         else $display("verification failed");
         $finish;
      end
   endtask
   task t_id;
      for (i = 0; i < 8; i++) begin
         @(posedge clk_sys);
         {id_weight_four_strap_n, id_weight_two_strap_n, id_weight_one_strap_n} <= ~i[2:0];
         repeat (6) @(posedge clk_sys);
         chk(target_id_ff, i[2:0], "id");
      end
   endtask
   task t_rx;
      begin
         host_model_i.xfer(1'h1, 1'h0, 1'h0, 8'hA5);
         chk(rx_byte_ff, 8'hA5, "rxbyte");
         chk(rx_is_data_ff, 1'h1, "isdata");
         chk(rx_parity_err_ff, 1'h0, "parerr");
         host_model_i.xfer(1'h1, 1'h1, 1'h1, 8'h3C);
         chk(rx_is_data_ff, 1'h0, "isdata");
         chk(rx_parity_err_ff, 1'h1, "parerr");
         chk(ack_n_ff, 1'h1, "ack");
         chk(n_rx_pulse[7:0], 8'h02, "rxpulses");
      end
   endtask
   task t_tx;
      begin
         host_model_i.xfer(1'h0, 1'h0, 1'h0, 8'h00);
         chk(db_n_out_ff, 8'h69, "txbyte");
         chk(parity_n_out_ff, 1'h0, "txpar");
         chk(db_oe_ff, 1'h1, "oe");
         chk(n_tx_pulse[7:0], 8'h01, "txpulses");
         chk(n_rx_pulse[7:0], 8'h02, "rxpulses");
      end
   endtask
   initial begin
      #20000;
      err_count++;
      wrap_up;
   end
   initial begin
      repeat (10) @(posedge clk_sys);
      reset <= 1'h0;
      t_id;
      t_rx;
      t_tx;
      wrap_up;
   end
endmodule
